// *** hw/code_seq_gen.sv ***
// Safety code sequencer: steps through the per-unit code table on each poll.
// Assumes step pulses come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module code_seq_gen #(
	parameter logic [4*curtain_pkg::CODE_LEN-1:0] TABLE = curtain_pkg::CODE_TABLE
) (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       clkEn,
	input  wire logic       run,
	input  wire logic       step,
	output logic [3:0]      safeCode
);
	import curtain_pkg::*;

	logic [3:0]            codeMem [CODE_LEN];
	logic [CODE_IDX_W-1:0] idx_r;

	genvar g;
	generate
		for (g = 0; g < CODE_LEN; g++) begin : g_tab
			assign codeMem[g] = TABLE[4*g +: 4];
		end
	endgenerate

	// Out of the ON state the code collapses to zero, which the monitor reads as off
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			idx_r    <= '0;
			safeCode <= 4'h0;
		end else if (clkEn) begin
			if (!run) begin
				idx_r    <= '0;
				safeCode <= 4'h0;
			end else if (step) begin
				idx_r    <= idx_r + 1'b1;                 // RULE3
				safeCode <= codeMem[idx_r];               // RULE3
			end
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	property p_code_step;
		clkEn && run && step |=> idx_r == $past(idx_r) + 1'b1 && safeCode == codeMem[$past(idx_r)];
	endproperty
	a_code_step: assert property (p_code_step) else $error("code step wrong"); // RULE3

	property p_code_idle;
		clkEn && !run |=> safeCode == 4'h0;
	endproperty
	a_code_idle: assert property (p_code_idle) else $error("code not zero when off"); // RULE3

endmodule // code_seq_gen
`default_nettype wire

// *** hw/curtain_pkg.sv ***
// Shared constants and carriers for the light curtain receiver status block.
// Assumes a single 250 MHz clock; times are converted to cycles here.
package curtain_pkg;

	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] PARAM_OFS  = 8'h00;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
	localparam int SEL_BIT   = 0;
	localparam int FAULT_BIT = 1;
	localparam int ST_LSB    = 0;
	localparam int WEAK_BIT  = 4;
	localparam int CLEAR_BIT = 5;
	localparam logic SEL_RST   = 1'b0;
	localparam logic FAULT_RST = 1'b1;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} busReq_s;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_KHZ         = 250000;
	localparam int RESTART_SHORT_MS = 100;
	localparam int RESTART_LONG_MS  = 500;
	localparam int SELFTEST_MS      = 10;
	localparam int FLASH_HALF_MS    = 125;
	localparam int RESTART_SHORT_CYC = RESTART_SHORT_MS * CLK_KHZ;
	localparam int RESTART_LONG_CYC  = RESTART_LONG_MS * CLK_KHZ;
	localparam int SELFTEST_CYC      = SELFTEST_MS * CLK_KHZ;
	localparam int FLASH_HALF_CYC    = FLASH_HALF_MS * CLK_KHZ;

	// ------------------------------------------------------------
	// Operating states and safety code
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_SELFTEST = 4'b0001,
		ST_OFF      = 4'b0010,
		ST_RESTART  = 4'b0100,
		ST_ON       = 4'b1000
	} opState_e;

	localparam int CODE_LEN = 8;
	localparam int CODE_IDX_W = 3;
	// Arbitrary per-unit code table, nibble 0 sent first
	localparam logic [4*CODE_LEN-1:0] CODE_TABLE = 32'h5A3C_96E1;

endpackage

// *** hw/curtain_status.sv ***
// Receiver status logic: self test, restart delay, lamp, fault flag, safety code.
// Assumes beam inputs arrive from the optics asynchronously; bus port is on this clock.
`timescale 1ns/10ps
`default_nettype none
// What the document requires of this block and its master
// [RULE1] Restart delay is 100 ms with select bit 0, 500 ms with 1.
// [RULE2] Fault flag reads 1 without interference, 0 after interference or periphery fault.
// [RULE3] Safe data bits carry the rotating safety code sequence, not plain values.
// [RULE4] Parameter bits are reachable only through the master's register port.
// [RULE5] The master must not use either parameter bit for safety decisions.
// [RULE6] After power-up a self test runs before normal operation.
// [RULE7] After self test the main lamp lights steadily green or red.
// [RULE8] Clear field gives the ON state with steady green lamp.
// [RULE9] Weak reception flashes green; red only once reception is lost.
// [RULE10] Master writes 1 to the fault flag, reads back; a fault clears it.
// [RULE11] Restart timer starts when field clears; ON only after continuously clear delay.
module curtain_status
	import curtain_pkg::*;
#(
	parameter int RESTART_SHORT = curtain_pkg::RESTART_SHORT_CYC,
	parameter int RESTART_LONG  = curtain_pkg::RESTART_LONG_CYC,
	parameter int SELFTEST      = curtain_pkg::SELFTEST_CYC,
	parameter int FLASH_HALF    = curtain_pkg::FLASH_HALF_CYC
) (
	input  wire logic                   clock,
	input  wire logic                   rst_n,
	input  wire logic                   clkEn,
	input  wire curtain_pkg::busReq_s   busReq,
	output logic [curtain_pkg::DATA_W-1:0] rdData,
	input  wire logic                   beamsClear,
	input  wire logic                   beamsWeak,
	input  wire logic                   interference,
	input  wire logic                   codeStep,
	output logic [3:0]                  safeCodeInputs,
	output logic                        lampGreen,
	output logic                        lampRed
);
	import curtain_pkg::*;

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic [2:0] pinMeta_r;
	logic [2:0] pinSync_r;
	logic       clearS;
	logic       weakS;
	logic       faultS;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pinMeta_r <= 3'h0;
			pinSync_r <= 3'h0;
		end else if (clkEn) begin
			pinMeta_r <= {interference, beamsWeak, beamsClear};
			pinSync_r <= pinMeta_r;
		end
	end

	assign clearS = pinSync_r[0];
	assign weakS  = pinSync_r[1];
	assign faultS = pinSync_r[2];

	// ------------------------------------------------------------
	// Parameter bits and register port
	// ------------------------------------------------------------
	logic delaySel_r;
	logic faultFlag_r;
	logic paramWr;

	function automatic logic hitOf(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
		hitOf = (a == ofs);
	endfunction

	// Only the master's port sets these bits; the fault input can also clear the fault flag
	assign paramWr = busReq.wr && hitOf(busReq.addr, PARAM_OFS);  // RULE4

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			delaySel_r <= SEL_RST;
		end else if (clkEn && paramWr) begin
			delaySel_r <= busReq.wdata[SEL_BIT];
		end
	end

	// A fault in the same cycle as the master's write of 1 still clears the flag
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			faultFlag_r <= FAULT_RST;
		end else if (clkEn) begin
			if (faultS) begin
				faultFlag_r <= 1'b0;                              // RULE2
			end else if (paramWr) begin
				faultFlag_r <= busReq.wdata[FAULT_BIT];           // RULE10
			end
		end
	end

	// ------------------------------------------------------------
	// Operating state machine
	// ------------------------------------------------------------
	opState_e    state_r;
	opState_e    state_nxt;
	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;
	logic [31:0] restartLim;
	logic        selfDone_r;

	assign restartLim = delaySel_r ? RESTART_LONG : RESTART_SHORT;  // RULE1

	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r + 32'h1;
		unique case (state_r)
			ST_SELFTEST: begin
				if (cnt_r == SELFTEST - 1) begin
					state_nxt = ST_OFF;                               // RULE6
					cnt_nxt   = 32'h0;
				end
			end
			ST_OFF: begin
				cnt_nxt = 32'h0;
				if (clearS) begin
					state_nxt = ST_RESTART;                           // RULE11
				end
			end
			ST_RESTART: begin
				if (!clearS) begin
					state_nxt = ST_OFF;                               // RULE11
					cnt_nxt   = 32'h0;
				end else if (cnt_r == restartLim - 1) begin
					state_nxt = ST_ON;                                // RULE1
					cnt_nxt   = 32'h0;
				end
			end
			ST_ON: begin
				cnt_nxt = 32'h0;
				if (!clearS) begin
					state_nxt = ST_OFF;
				end
			end
			default: begin
				state_nxt = ST_SELFTEST;
				cnt_nxt   = 32'h0;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_r <= ST_SELFTEST;
			cnt_r   <= 32'h0;
		end else if (clkEn) begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			selfDone_r <= 1'b0;
		end else if (clkEn && state_r == ST_SELFTEST && state_nxt == ST_OFF) begin
			selfDone_r <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Main status lamp
	// ------------------------------------------------------------
	logic [31:0] flashCnt_r;
	logic        flashOn_r;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			flashCnt_r <= 32'h0;
			flashOn_r  <= 1'b1;
		end else if (clkEn) begin
			if (flashCnt_r == FLASH_HALF - 1) begin
				flashCnt_r <= 32'h0;
				flashOn_r  <= ~flashOn_r;
			end else begin
				flashCnt_r <= flashCnt_r + 32'h1;
			end
		end
	end

	// Lamps follow the next state so they never lag the state register
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			lampGreen <= 1'b0;
			lampRed   <= 1'b0;
		end else if (clkEn) begin
			lampGreen <= (state_nxt == ST_ON) && (!weakS || flashOn_r);  // RULE8 RULE9
			lampRed   <= (state_nxt == ST_OFF) || (state_nxt == ST_RESTART); // RULE7 RULE9
		end
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rdData <= '0;
		end else if (clkEn) begin
			rdData <= '0;
			if (busReq.rd && hitOf(busReq.addr, PARAM_OFS)) begin
				rdData[SEL_BIT]   <= delaySel_r;
				rdData[FAULT_BIT] <= faultFlag_r;                     // RULE10
			end else if (busReq.rd && hitOf(busReq.addr, STATUS_OFS)) begin
				rdData[ST_LSB +: 4] <= state_r;
				rdData[WEAK_BIT]    <= weakS;
				rdData[CLEAR_BIT]   <= clearS;
			end
		end
	end

	// ------------------------------------------------------------
	// Safety code
	// ------------------------------------------------------------
	code_seq_gen u_code (
		.clock    (clock),
		.rst_n    (rst_n),
		.clkEn    (clkEn),
		.run      (state_r == ST_ON),                                 // RULE3
		.step     (codeStep),
		.safeCode (safeCodeInputs)
	);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	property p_restart_done;
		clkEn && state_r == ST_RESTART && clearS && cnt_r == restartLim - 1 |=> state_r == ST_ON;
	endproperty
	a_restart_done: assert property (p_restart_done) else $error("restart delay exit wrong"); // RULE1

	// ON may only be entered from RESTART at the last count of the selected delay
	property p_restart_early;
		state_r == ST_ON && $past(state_r) != ST_ON |->
			$past(state_r) == ST_RESTART && $past(cnt_r) == $past(restartLim) - 32'h1;
	endproperty
	a_restart_early: assert property (p_restart_early) else $error("ON entered early"); // RULE1

	property p_fault_clear;
		clkEn && faultS |=> !faultFlag_r;
	endproperty
	a_fault_clear: assert property (p_fault_clear) else $error("fault did not clear flag"); // RULE2

	property p_flag_arm;
		clkEn && paramWr && busReq.wdata[FAULT_BIT] && !faultS |=> faultFlag_r;
	endproperty
	a_flag_arm: assert property (p_flag_arm) else $error("flag write of 1 lost"); // RULE10

	property p_selftest_first;
		state_r != ST_SELFTEST |-> selfDone_r;
	endproperty
	a_selftest_first: assert property (p_selftest_first) else $error("left self test early"); // RULE6

	property p_ready_lamp;
		state_r == ST_OFF |-> lampRed && !lampGreen;
	endproperty
	a_ready_lamp: assert property (p_ready_lamp) else $error("ready lamp wrong"); // RULE7

	property p_on_green;
		clkEn && state_nxt == ST_ON && !weakS |=> lampGreen && !lampRed;
	endproperty
	a_on_green: assert property (p_on_green) else $error("ON lamp not green"); // RULE8

	property p_weak_no_red;
		state_r == ST_ON |-> !lampRed;
	endproperty
	a_weak_no_red: assert property (p_weak_no_red) else $error("red while beams received"); // RULE9

	property p_restart_abort;
		clkEn && state_r == ST_RESTART && !clearS |=> state_r == ST_OFF;
	endproperty
	a_restart_abort: assert property (p_restart_abort) else $error("restart not aborted"); // RULE11

	property p_param_read;
		clkEn && busReq.rd && hitOf(busReq.addr, PARAM_OFS) |=>
			rdData[FAULT_BIT] == $past(faultFlag_r) && rdData[SEL_BIT] == $past(delaySel_r);
	endproperty
	a_param_read: assert property (p_param_read) else $error("parameter read wrong"); // RULE10

	c_reach_on: cover property (state_r == ST_RESTART ##1 state_r == ST_ON);
	c_weak_flash: cover property (state_r == ST_ON && weakS && !lampGreen);
	c_fault_seen: cover property (faultFlag_r ##1 !faultFlag_r);
	c_long_delay: cover property (delaySel_r && state_r == ST_ON);

endmodule // curtain_status
`default_nettype wire

// *** tb/bus_master_model.sv ***
// Bus master model: the only party that reaches the parameter bits.
// Assumes one clock shared with the receiver; reads return one cycle later.
`timescale 1ns/10ps
`default_nettype none
module bus_master_model
	import curtain_pkg::*;
(
	input  wire logic                 clock,
	output var curtain_pkg::busReq_s  busReq,
	input  wire logic [DATA_W-1:0]    rdData
);
	initial busReq = '0;

	// ------------------------------------------------------------
	// Bus cycles
	// ------------------------------------------------------------
	// Sole driver of the parameter port; no other requester exists
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clock);
		busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		busReq.wr <= 1'b0;
	endtask

	// Flag is read back both before and after arming it; value is never used for safety
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge clock);
		busReq <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		busReq.rd <= 1'b0;
		#1 d = rdData;
	endtask
endmodule // bus_master_model
`default_nettype wire

// *** tb/curtain_status_tb.sv ***
// Self-checking bench for the receiver status block.
// Assumes shortened timing parameters; bus traffic goes through the master model.
`timescale 1ns/10ps
`default_nettype none
module curtain_status_tb;
	import curtain_pkg::*;
	localparam int SHORT = 20;
	localparam int LONG  = 50;
	localparam int SELF  = 10;
	logic              clock;
	logic              rst_n;
	logic              clkEn;
	busReq_s           busReq;
	logic [DATA_W-1:0] rdData;
	logic              beamsClear;
	logic              beamsWeak;
	logic              interference;
	logic              codeStep;
	logic [3:0]        safeCodeInputs;
	logic              lampGreen;
	logic              lampRed;
	logic [DATA_W-1:0] d;
	int                mismatches;
	int                samples_checked;
	int                cycles;

	curtain_status #(.RESTART_SHORT(SHORT), .RESTART_LONG(LONG), .SELFTEST(SELF),
		.FLASH_HALF(4)) curtain_status_inst (.clock(clock), .rst_n(rst_n), .clkEn(clkEn),
		.busReq(busReq), .rdData(rdData), .beamsClear(beamsClear), .beamsWeak(beamsWeak),
		.interference(interference), .codeStep(codeStep), .safeCodeInputs(safeCodeInputs),
		.lampGreen(lampGreen), .lampRed(lampRed));
	bus_master_model bus_master_model_inst (.clock(clock), .busReq(busReq), .rdData(rdData));

	// ------------------------------------------------------------
	// Clock, timeout and reporting
	// ------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			mismatches = mismatches + 1;
			end_of_test();
		end
	end

	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		samples_checked = samples_checked + 1;
		if (seen !== exp) begin
			mismatches = mismatches + 1;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("compares=%0d mismatches=%0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic waitc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_selftest();
		bus_master_model_inst.rd(STATUS_OFS, d);
		check(d, 32'h1);
		check({lampGreen, lampRed}, 2'b00);
		waitc(SELF + 6);
		bus_master_model_inst.rd(STATUS_OFS, d);
		check(d[3:0], 4'h2);
		check({lampGreen, lampRed}, 2'b01);
		check(safeCodeInputs, 4'h0);
	endtask

	task automatic t_fault();
		bus_master_model_inst.rd(PARAM_OFS, d);
		check(d, 32'h2);
		@(posedge clock) interference <= 1'b1;
		waitc(3);
		interference <= 1'b0;
		bus_master_model_inst.rd(PARAM_OFS, d);
		check(d[FAULT_BIT], 1'b0);
		bus_master_model_inst.wr(PARAM_OFS, 32'h2);
		bus_master_model_inst.rd(PARAM_OFS, d);
		check(d[FAULT_BIT], 1'b1);
	endtask

	// Read-only and unmapped places must not take or return data
	task automatic t_map();
		bus_master_model_inst.wr(STATUS_OFS, 32'hFF);
		bus_master_model_inst.rd(STATUS_OFS, d);
		check(d[3:0], 4'h2);
		bus_master_model_inst.rd(8'h08, d);
		check(d, 32'h0);
	endtask

	// A brief break restarts the delay count from zero
	task automatic t_short();
		@(posedge clock) beamsClear <= 1'b1;
		waitc(15);
		beamsClear <= 1'b0;
		waitc(4);
		beamsClear <= 1'b1;
		waitc(SHORT);
		check(lampGreen, 1'b0);
		check(lampRed, 1'b1);
		waitc(8);
		check({lampGreen, lampRed}, 2'b10);
		codeStep <= 1'b1;
		waitc(1);
		codeStep <= 1'b0;
		waitc(1);
		check(safeCodeInputs, CODE_TABLE[3:0]);
		codeStep <= 1'b1;
		waitc(1);
		codeStep <= 1'b0;
		waitc(1);
		check(safeCodeInputs, CODE_TABLE[7:4]);
	endtask

	task automatic t_weak();
		int highs;
		int reds;
		highs = 0;
		reds = 0;
		beamsWeak <= 1'b1;
		waitc(4);
		repeat (16) begin
			waitc(1);
			highs = highs + int'(lampGreen === 1'b1);
			reds = reds + int'(lampRed !== 1'b0);
		end
		check(highs > 0 && highs < 16, 1'b1);
		check(reds, 0);
		bus_master_model_inst.rd(STATUS_OFS, d);
		check(d, 32'h38);
		beamsClear <= 1'b0;
		beamsWeak <= 1'b0;
		waitc(6);
		check({lampGreen, lampRed}, 2'b01);
		check(safeCodeInputs, 4'h0);
	endtask

	task automatic t_long();
		bus_master_model_inst.wr(PARAM_OFS, 32'h3);
		bus_master_model_inst.rd(PARAM_OFS, d);
		check(d[1:0], 2'b11);
		beamsClear <= 1'b1;
		waitc(SHORT + 8);
		check(lampGreen, 1'b0);
		waitc(LONG - SHORT - 6);
		check(lampGreen, 1'b0);
		waitc(1);
		check({lampGreen, lampRed}, 2'b10);
	endtask

	// Enable low freezes sync flops and state; the field loss shows only after it returns
	task automatic t_freeze();
		clkEn <= 1'b0;
		beamsClear <= 1'b0;
		waitc(6);
		check({lampGreen, lampRed}, 2'b10);
		clkEn <= 1'b1;
		waitc(4);
		check({lampGreen, lampRed}, 2'b01);
	endtask

	// A mid-run reset restores the power-up parameter values and reruns the self test
	task automatic t_reset();
		rst_n <= 1'b0;
		waitc(2);
		check({lampGreen, lampRed, safeCodeInputs}, 6'h00);
		rst_n <= 1'b1;
		bus_master_model_inst.rd(PARAM_OFS, d);
		check(d, 32'h2);
		bus_master_model_inst.rd(STATUS_OFS, d);
		check(d, 32'h1);
	endtask

	initial begin
		rst_n = 1'b0;
		beamsClear = 1'b0;
		beamsWeak = 1'b0;
		interference = 1'b0;
		codeStep = 1'b0;
		clkEn = 1'b1;
		mismatches = 0;
		samples_checked = 0;
		cycles = 0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		t_selftest();
		t_fault();
		t_map();
		t_short();
		t_weak();
		t_long();
		t_freeze();
		t_reset();
		end_of_test();
	end
endmodule // curtain_status_tb
`default_nettype wire
